/* hw/dbgtc_top.sv */
// Debug trigger control: control and trigger registers, trigger decode, loop capture.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "dbgtc_consts.svh"

module dbgtc_top
    import dbgtc_pkg::*;
#(
    parameter int ADDR_W = 17
)
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic end_trace_reset_in,
    input wire logic secure_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic match_a_access_in,
    input wire logic match_a_exec_in,
    input wire logic match_b_access_in,
    input wire logic match_b_exec_in,
    input wire logic range_inside_in,
    input wire logic range_outside_in,
    input wire logic match_c_in,
    input wire logic change_of_flow_in,
    input wire logic [ADDR_W-1:0] cof_addr_in,
    input wire logic paged_access_flag_in,
    output logic fifo_wr_out,
    output logic [ADDR_W-1:0] fifo_addr_out,
    output logic fifo_paged_out,
    output logic count_inc_out,
    output logic [ADDR_W-1:0] comp_c_addr_out,
    output logic trigger_out,
    output logic storing_out,
    output logic break_req_out,
    output logic break_tag_out,
    output logic debug_module_enable_out,
    output logic armed_out
);

    logic [7:0] ctl_ff;
    logic [7:0] trg_ff;
    logic [7:0] rdata_ff;
    logic [ADDR_W-1:0] comp_c_ff;
    logic fifo_wr_ff;
    logic [ADDR_W-1:0] fifo_addr_ff;
    logic fifo_paged_ff;
    logic count_inc_ff;
    logic trig_ff;
    logic break_ff;
    logic end_run_ff;
    dbgtc_state_t state_ff;
    dbgtc_state_t nxt_state;
    logic en;
    logic armed;
    logic loop_sel;
    logic match_a;
    logic match_b;
    logic hit;
    logic event_only;
    logic cof_store;
    logic cof_same;

    assign en = ctl_ff[`DBGTC_CTL_ENABLE_BIT];
    assign armed = en & ctl_ff[`DBGTC_CTL_ARM_BIT];
    assign loop_sel = ctl_ff[`DBGTC_CTL_LOOP_BIT];

    // Control register; secure state forces enable low so debug cannot peek at secured code.
    always_ff @(posedge clk_in)
    begin
        if (srst_in && end_trace_reset_in && en && !trg_ff[`DBGTC_TRG_BEGIN_BIT])
        begin
            ctl_ff[`DBGTC_CTL_ARM_BIT] <= 1'b0;
            ctl_ff[`DBGTC_CTL_BREAK_REQUEST_ENABLE_BIT] <= 1'b0;
            if (secure_in)
            begin
                ctl_ff[`DBGTC_CTL_ENABLE_BIT] <= 1'b0;
            end
        end
        else if (srst_in)
        begin
            ctl_ff <= `DBGTC_CTL_RESET;
            if (secure_in)
            begin
                ctl_ff[`DBGTC_CTL_ENABLE_BIT] <= 1'b0;
            end
        end
        else
        begin
            if (wr_in && addr_in == `DBGTC_OFS_CONTROL)
            begin
                ctl_ff <= wdata_in & `DBGTC_CTL_WMASK;
            end
            else if (end_run_ff)
            begin
                ctl_ff[`DBGTC_CTL_ARM_BIT] <= 1'b0;
            end
            if (secure_in)
            begin
                ctl_ff[`DBGTC_CTL_ENABLE_BIT] <= 1'b0;
            end
        end
    end

    // Trigger register; locked while the arm bit is set, even with enable low, so a running capture sees stable settings.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            if (!(end_trace_reset_in && en && !trg_ff[`DBGTC_TRG_BEGIN_BIT]))
            begin
                trg_ff <= `DBGTC_TRG_RESET;
            end
        end
        else if (wr_in && addr_in == `DBGTC_OFS_TRIGGER && !ctl_ff[`DBGTC_CTL_ARM_BIT])
        begin
            trg_ff <= wdata_in & `DBGTC_TRG_WMASK;
        end
    end

    // Read data is valid in the cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            rdata_ff <= 8'h00;
        end
        else if (rd_in && addr_in == `DBGTC_OFS_CONTROL)
        begin
            rdata_ff <= ctl_ff & `DBGTC_CTL_WMASK;
        end
        else if (rd_in && addr_in == `DBGTC_OFS_TRIGGER)
        begin
            rdata_ff <= trg_ff;
        end
        else
        begin
            rdata_ff <= 8'h00;
        end
    end

    // Comparator selection: access match or execution match.
    assign match_a = trg_ff[`DBGTC_TRG_EXEC_BIT] ? match_a_exec_in : match_a_access_in;
    assign match_b = trg_ff[`DBGTC_TRG_EXEC_BIT] ? match_b_exec_in : match_b_access_in;
    assign event_only = (trg_ff[3:0] == DBGTC_EV_ONLY_B) || (trg_ff[3:0] == DBGTC_A_THEN_EV_B);

    // Trigger sequencer; sequential modes wait for A before looking at B.
    always_comb
    begin
        nxt_state = state_ff;
        hit = 1'b0;
        case (state_ff)
            DBGTC_ST_IDLE:
            begin
                case (trg_ff[3:0])
                    DBGTC_A_ONLY: hit = match_a;
                    DBGTC_A_OR_B: hit = match_a | match_b;
                    DBGTC_EV_ONLY_B: hit = match_b;
                    DBGTC_A_THEN_B, DBGTC_A_THEN_EV_B:
                    begin
                        if (match_a)
                        begin
                            nxt_state = DBGTC_ST_WAIT_B;
                        end
                    end
                    DBGTC_A_AND_B: hit = match_a & match_b;
                    DBGTC_A_AND_NOT_B: hit = match_a & !match_b;
                    DBGTC_INSIDE: hit = range_inside_in;
                    DBGTC_OUTSIDE: hit = range_outside_in;
                    default: hit = 1'b0;
                endcase
            end
            DBGTC_ST_WAIT_B: hit = match_b;
            DBGTC_ST_DONE: hit = 1'b0;
            default: nxt_state = DBGTC_ST_IDLE;
        endcase
        if (hit)
        begin
            nxt_state = DBGTC_ST_DONE;
        end
        if (!armed)
        begin
            nxt_state = DBGTC_ST_IDLE;
            hit = 1'b0;
        end
    end

    // Sequencer state and end-of-run pulse.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            state_ff <= DBGTC_ST_IDLE;
            trig_ff <= 1'b0;
            end_run_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            trig_ff <= hit;
            end_run_ff <= hit & !trg_ff[`DBGTC_TRG_BEGIN_BIT];
        end
    end

    // Storage runs before the trigger in end mode, after it in begin mode.
    assign storing_out = armed && (trg_ff[`DBGTC_TRG_BEGIN_BIT] ?
        (state_ff == DBGTC_ST_DONE) : (state_ff != DBGTC_ST_DONE));

    // Loop capture: repeated change-of-flow addresses held in comparator C are dropped.
    assign cof_store = storing_out && change_of_flow_in && !event_only;
    assign cof_same = loop_sel && !event_only && cof_addr_in == comp_c_ff;

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            fifo_wr_ff <= 1'b0;
            count_inc_ff <= 1'b0;
            fifo_addr_ff <= '0;
            fifo_paged_ff <= 1'b0;
        end
        else
        begin
            fifo_wr_ff <= cof_store && !cof_same;
            count_inc_ff <= cof_store && !cof_same;
            if (cof_store && !cof_same)
            begin
                fifo_addr_ff <= cof_addr_in;
                fifo_paged_ff <= paged_access_flag_in;
            end
        end
    end

    // Comparator C tracks the last captured address only in loop mode.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            comp_c_ff <= '0;
        end
        else if (cof_store && !cof_same && loop_sel)
        begin
            comp_c_ff <= cof_addr_in;
        end
    end

    // Break request at end of run or, outside loop mode, on comparator C, only when break enable is set.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            break_ff <= 1'b0;
        end
        else
        begin
            break_ff <= en && ctl_ff[`DBGTC_CTL_BREAK_REQUEST_ENABLE_BIT] &&
                (end_run_ff || (match_c_in && !loop_sel));
        end
    end

    assign rdata_out = rdata_ff;
    assign fifo_wr_out = fifo_wr_ff;
    assign fifo_addr_out = fifo_addr_ff;
    assign fifo_paged_out = fifo_paged_ff;
    assign count_inc_out = count_inc_ff;
    assign comp_c_addr_out = comp_c_ff;
    assign trigger_out = trig_ff;
    assign break_req_out = break_ff;
    // Tag selection only matters while a break request can be raised.
    assign break_tag_out = ctl_ff[`DBGTC_CTL_TAG_BIT] & ctl_ff[`DBGTC_CTL_BREAK_REQUEST_ENABLE_BIT];
    assign debug_module_enable_out = en;
    assign armed_out = armed;

endmodule : dbgtc_top

/* hw/dbgtc_consts.svh */
// Offsets, field positions, reset values and write masks of the debug trigger control block.
`ifndef DBGTC_CONSTS_SVH
`define DBGTC_CONSTS_SVH
`define DBGTC_OFS_CONTROL 8'h0C
`define DBGTC_OFS_TRIGGER 8'h0D
`define DBGTC_CTL_ENABLE_BIT 7
`define DBGTC_CTL_ARM_BIT 6
`define DBGTC_CTL_TAG_BIT 5
`define DBGTC_CTL_BREAK_REQUEST_ENABLE_BIT 4
`define DBGTC_CTL_LOOP_BIT 0
`define DBGTC_TRG_EXEC_BIT 7
`define DBGTC_TRG_BEGIN_BIT 6
`define DBGTC_CTL_RESET 8'hC0
`define DBGTC_CTL_WMASK 8'hF1
`define DBGTC_TRG_RESET 8'h00
`define DBGTC_TRG_WMASK 8'hCF
`endif

/* hw/dbgtc_pkg.sv */
// Types shared by the debug trigger control block.
package dbgtc_pkg;
    typedef enum logic [3:0]
    {
        DBGTC_A_ONLY = 4'h0,
        DBGTC_A_OR_B = 4'h1,
        DBGTC_A_THEN_B = 4'h2,
        DBGTC_EV_ONLY_B = 4'h3,
        DBGTC_A_THEN_EV_B = 4'h4,
        DBGTC_A_AND_B = 4'h5,
        DBGTC_A_AND_NOT_B = 4'h6,
        DBGTC_INSIDE = 4'h7,
        DBGTC_OUTSIDE = 4'h8
    } dbgtc_mode_t;
    typedef enum logic [2:0]
    {
        DBGTC_ST_IDLE = 3'b001,
        DBGTC_ST_WAIT_B = 3'b010,
        DBGTC_ST_DONE = 3'b100
    } dbgtc_state_t;
endpackage : dbgtc_pkg

/* testbench/dbgtc_top_props.sv */
// Assertion checker for the debug trigger control block.
`timescale 1ns/1ps
module dbgtc_top_props
#(
    parameter int ADDR_W = 17
)
(
    input wire logic clk_in, srst_in, end_trace_reset_in, secure_in,
    input wire logic [7:0] addr_in, wdata_in, rdata_out,
    input wire logic wr_in, rd_in, change_of_flow_in, paged_access_flag_in,
    input wire logic [ADDR_W-1:0] cof_addr_in, fifo_addr_out, comp_c_addr_out,
    input wire logic fifo_wr_out, fifo_paged_out, count_inc_out, trigger_out, storing_out,
    input wire logic break_req_out, break_tag_out, debug_module_enable_out, armed_out
);
    logic tag_ff, brk_ff, loop_ff;
    // Shadow of the control bits; an end-trace reset keeps tag and loop but drops break.
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            brk_ff <= 1'b0;
            if (!end_trace_reset_in)
            begin
                tag_ff <= 1'b0;
                loop_ff <= 1'b0;
            end
        end
        else if (wr_in && addr_in == 8'h0C)
        begin
            tag_ff <= wdata_in[5];
            brk_ff <= wdata_in[4];
            loop_ff <= wdata_in[0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_secure_enable: assert property (secure_in ##1 secure_in |-> !debug_module_enable_out)
        else $error("enable set while secure");
    a_fifo_cause: assert property (fifo_wr_out |-> $past(change_of_flow_in && armed_out && storing_out))
        else $error("capture without armed store");
    a_trig_armed: assert property (trigger_out |-> $past(armed_out))
        else $error("trigger while disarmed");
    a_count_pair: assert property (count_inc_out == fifo_wr_out)
        else $error("count and write differ");
    a_fifo_data: assert property (fifo_wr_out |-> fifo_addr_out == $past(cof_addr_in)
        && fifo_paged_out == $past(paged_access_flag_in))
        else $error("captured address wrong");
    a_loop_skip: assert property (loop_ff && change_of_flow_in && cof_addr_in == comp_c_addr_out
        |=> !fifo_wr_out)
        else $error("repeat not suppressed");
    a_loop_track: assert property (loop_ff && fifo_wr_out |-> comp_c_addr_out == fifo_addr_out)
        else $error("comparator C not loaded");
    a_no_break: assert property (!brk_ff |-> !break_req_out && !break_tag_out)
        else $error("break while disabled");
    a_tag_sel: assert property (brk_ff |-> break_tag_out == tag_ff)
        else $error("break kind wrong");
    a_rd_rsvd: assert property ($past(rd_in && addr_in == 8'h0C) |-> rdata_out[3:1] == 3'h0)
        else $error("reserved bits not zero");
endmodule : dbgtc_top_props
bind dbgtc_top dbgtc_top_props #(.ADDR_W(ADDR_W)) u_props (.clk_in(clk_in), .srst_in(srst_in),
    .end_trace_reset_in(end_trace_reset_in), .secure_in(secure_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .wr_in(wr_in), .rd_in(rd_in),
    .change_of_flow_in(change_of_flow_in), .paged_access_flag_in(paged_access_flag_in),
    .cof_addr_in(cof_addr_in), .fifo_addr_out(fifo_addr_out), .comp_c_addr_out(comp_c_addr_out),
    .fifo_wr_out(fifo_wr_out), .fifo_paged_out(fifo_paged_out), .count_inc_out(count_inc_out),
    .trigger_out(trigger_out), .storing_out(storing_out), .break_req_out(break_req_out),
    .break_tag_out(break_tag_out), .debug_module_enable_out(debug_module_enable_out),
    .armed_out(armed_out));

/* testbench/dbgtc_core_model.sv */
// Processor core stand-in that counts break requests by kind.
`timescale 1ns/1ps
module dbgtc_core_model
(
    input wire logic clk_in,
    input wire logic break_req_in,
    input wire logic break_tag_in,
    output int tag_cnt_out,
    output int force_cnt_out
);
    initial tag_cnt_out = 0;
    initial force_cnt_out = 0;
    // The core takes each request at the edge; tag and force are counted apart.
    always @(posedge clk_in)
    begin
        if (break_req_in === 1'b1 && break_tag_in === 1'b1)
            tag_cnt_out++;
        else if (break_req_in === 1'b1)
            force_cnt_out++;
    end
endmodule : dbgtc_core_model

/* testbench/dbgtc_top_tb.sv */
// Self-checking testbench for the debug trigger control block.
`timescale 1ns/1ps
module dbgtc_top_tb;
    logic clk_in = 0, srst_in = 1, etr = 0, sec = 0, wr = 0, rd = 0, change_of_flow = 0, pg = 0;
    logic ma = 0, mx = 0, zero = 0, fwr, trigger_mode_field, brq, btag, arm;
    logic [7:0] addr = 0, wdata = 0, rdata;
    logic [16:0] caddr = 0;
    int num_errors = 0, checks = 0, trig_n = 0, fifo_n = 0, tag_n, force_n;
    always #10 clk_in = ~clk_in;
    dbgtc_top uut (.clk_in(clk_in), .srst_in(srst_in), .end_trace_reset_in(etr),
        .secure_in(sec), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .match_a_access_in(ma), .match_a_exec_in(mx),
        .match_b_access_in(ma), .match_b_exec_in(mx), .range_inside_in(ma),
        .range_outside_in(zero), .match_c_in(zero), .change_of_flow_in(change_of_flow),
        .cof_addr_in(caddr), .paged_access_flag_in(pg), .fifo_wr_out(fwr), .fifo_addr_out(),
        .fifo_paged_out(), .count_inc_out(), .comp_c_addr_out(), .trigger_out(trigger_mode_field),
        .storing_out(), .break_req_out(brq), .break_tag_out(btag),
        .debug_module_enable_out(), .armed_out(arm));
    dbgtc_core_model core (.clk_in(clk_in), .break_req_in(brq), .break_tag_in(btag),
        .tag_cnt_out(tag_n), .force_cnt_out(force_n));
    // Pulses are one cycle long, so they are tallied at every edge.
    always @(posedge clk_in)
    begin
        trig_n += (trigger_mode_field === 1'b1);
        fifo_n += (fwr === 1'b1);
    end
    task automatic give_verdict();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so it is sampled just past that edge.
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd_reg
    task automatic do_reset(input logic e, input logic s);
        @(posedge clk_in);
        srst_in <= 1'b1;
        etr <= e;
        sec <= s;
        @(posedge clk_in);
        srst_in <= 1'b0;
        etr <= 1'b0;
    endtask : do_reset
    // Disarm first: the trigger register refuses writes while armed.
    task automatic trig(input logic [7:0] c, input logic [7:0] t, input logic x, input logic e);
        int n;
        wr_reg(8'h0C, 8'h80);
        wr_reg(8'h0D, t);
        wr_reg(8'h0C, c);
        n = trig_n;
        @(posedge clk_in);
        ma <= !x;
        mx <= x;
        @(posedge clk_in);
        ma <= 1'b0;
        mx <= 1'b0;
        repeat (3) @(posedge clk_in);
        chk({7'h0, trig_n != n}, {7'h0, e});
    endtask : trig
    task automatic cof_ev(input logic [16:0] a, input logic p);
        @(posedge clk_in);
        caddr <= a;
        pg <= p;
        change_of_flow <= 1'b1;
        @(posedge clk_in);
        change_of_flow <= 1'b0;
    endtask : cof_ev
    initial
    begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        give_verdict();
    end
    initial
    begin
        int base;
        repeat (12) @(posedge clk_in);
        srst_in <= 1'b0;
        rd_reg(8'h0C, 8'hC0);
        rd_reg(8'h0E, 8'h00);
        wr_reg(8'h0D, 8'h4F);
        rd_reg(8'h0D, 8'h00);
        wr_reg(8'h0C, 8'hFF);
        rd_reg(8'h0C, 8'hF1);
        for (int i = 0; i < 16; i++)
            trig(8'hC0, 8'h40 | 8'(i), 1'b0, 1'(16'h00AB >> i));
        trig(8'hC0, 8'hC0, 1'b0, 1'b0);
        trig(8'hC0, 8'hC0, 1'b1, 1'b1);
        chk(8'(tag_n + force_n), 8'h00);
        trig(8'hF0, 8'h00, 1'b0, 1'b1);
        chk({7'h0, arm}, 8'h00);
        chk(8'(tag_n), 8'h01);
        trig(8'hD0, 8'h00, 1'b0, 1'b1);
        chk(8'(force_n), 8'h01);
        wr_reg(8'h0C, 8'hC1);
        base = fifo_n;
        cof_ev(17'h1ABCD, 1'b1);
        cof_ev(17'h1ABCD, 1'b1);
        cof_ev(17'h00123, 1'b0);
        repeat (2) @(posedge clk_in);
        chk(8'(fifo_n - base), 8'h02);
        trig(8'hC1, 8'h43, 1'b0, 1'b1);
        cof_ev(17'h00456, 1'b0);
        repeat (2) @(posedge clk_in);
        chk(8'(fifo_n - base), 8'h02);
        wr_reg(8'h0C, 8'hB1);
        wr_reg(8'h0D, 8'h05);
        do_reset(1'b1, 1'b0);
        rd_reg(8'h0C, 8'hA1);
        rd_reg(8'h0D, 8'h05);
        do_reset(1'b0, 1'b1);
        rd_reg(8'h0C, 8'h40);
        wr_reg(8'h0C, 8'hC0);
        rd_reg(8'h0C, 8'h40);
        give_verdict();
    end
endmodule : dbgtc_top_tb
